// *** rtl/ccpm_top.sv ***
// Purpose: Mode selection and attach/removal detection for a charging port
// Assumes: All inputs synchronous to i_core_clk; APB slave, zero wait
// Notes: Registers CTRL, STATUS (W1C), MASK, STATE
//
// Register access over APB and the register addresses were chosen for this implementation.
`include "ccpm_consts.svh"

module ccpm_top
    import ccpm_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire ccpm_apb_req_t i_apb,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire ccpm_mode_t i_mode,
    input wire logic i_port_power_enable,
    input wire logic i_detect_feature_enable,
    input wire logic i_load_present,
    input wire logic i_dp_driven,
    input wire logic i_profile_cycling_pass,
    output logic o_hs_switch_closed,
    output logic o_const_current,
    output logic o_attached,
    output logic o_irq
);

    ccpm_state_t st_r, st_nxt, st_dec;
    ccpm_mode_t mode_r;
    logic vld_r, pwr_r;
    logic mode_chg, pwr_rise, force_rem, fall, suppress;
    logic att_evt, rem_evt, miss_evt;
    logic armed_r, attached_r, dp_seen_r;
    logic [11:0] cur_lim_r;
    logic tdis_r;
    logic [2:0] mask_r;
    logic [2:0] status;
    logic [2:0] clr;
    logic setup, wr, mapped;
    logic [31:0] rd_val;

    // Input history for change detection
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            vld_r <= 1'b0;
            mode_r <= '0;
            pwr_r <= 1'b0;
        end else begin
            vld_r <= 1'b1;
            mode_r <= i_mode;
            pwr_r <= i_port_power_enable;
        end
    end

    assign mode_chg = vld_r & (i_mode != mode_r);
    assign pwr_rise = vld_r & i_port_power_enable & ~pwr_r;

    // Mode decode from select pins
    always_comb begin
        case ({i_mode.mode_select_one, i_mode.mode_select_two, i_mode.emulation_enable})
            3'h2, 3'h6: st_dec = CCPM_ST_PASS;
            3'h7: st_dec = CCPM_ST_CDP;
            3'h3: st_dec = CCPM_ST_DCP;
            default: st_dec = CCPM_ST_SLEEP;
        endcase
    end

    // Leaving pass-through needs a mode change; host powers up first
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            CCPM_ST_PASS: begin
                if (mode_chg) begin
                    st_nxt = i_port_power_enable ? st_dec : CCPM_ST_SLEEP;
                end
            end
            CCPM_ST_SLEEP, CCPM_ST_CDP, CCPM_ST_DCP: begin
                st_nxt = i_port_power_enable ? st_dec : CCPM_ST_SLEEP;
            end
            default: st_nxt = CCPM_ST_SLEEP;
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_r <= CCPM_ST_SLEEP;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Switch closed only in pass-through and charging-downstream
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_hs_switch_closed <= 1'b0;
        end else begin
            o_hs_switch_closed <= (st_nxt == CCPM_ST_PASS) || (st_nxt == CCPM_ST_CDP);
        end
    end

    // Limit behaviour: constant current or trip
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_const_current <= 1'b0;
        end else begin
            o_const_current <= (st_r == CCPM_ST_CDP) && (cur_lim_r < `CCPM_CURLIM_CC_MAX_MA);
        end
    end

    // Detection events
    assign force_rem = i_detect_feature_enable & (mode_chg | pwr_rise);
    assign fall = attached_r & ~i_load_present;
    assign suppress = ((st_r == CCPM_ST_CDP) & ~dp_seen_r)
                    | (tdis_r & i_profile_cycling_pass);
    assign rem_evt = force_rem | (i_detect_feature_enable & fall & ~suppress);
    assign miss_evt = i_detect_feature_enable & ~force_rem & fall & suppress;
    assign att_evt = i_detect_feature_enable & ~force_rem & armed_r & ~attached_r & i_load_present;

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            attached_r <= 1'b0;
        end else if (!i_detect_feature_enable || force_rem) begin
            attached_r <= 1'b0;
        end else if (rem_evt || miss_evt) begin
            attached_r <= 1'b0;
        end else if (att_evt) begin
            attached_r <= 1'b1;
        end
    end

    // Missed removal still re-arms attach
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            armed_r <= 1'b1;
        end else if (!i_detect_feature_enable || force_rem || rem_evt || miss_evt) begin
            armed_r <= 1'b1;
        end else if (att_evt) begin
            armed_r <= 1'b0;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            dp_seen_r <= 1'b0;
        end else if (att_evt) begin
            dp_seen_r <= i_dp_driven;
        end else if (attached_r && i_dp_driven) begin
            dp_seen_r <= 1'b1;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_attached <= 1'b0;
        end else begin
            o_attached <= att_evt | (attached_r & ~(rem_evt | miss_evt) & i_detect_feature_enable & ~force_rem);
        end
    end

    // APB slave, answers in the first access cycle
    assign setup = i_apb.psel & ~i_apb.penable;
    assign wr = i_apb.psel & i_apb.penable & i_apb.pwrite & o_pready & ~o_pslverr;
    assign mapped = (i_apb.paddr == `CCPM_OFS_CTRL) || (i_apb.paddr == `CCPM_OFS_STATUS)
                 || (i_apb.paddr == `CCPM_OFS_MASK) || (i_apb.paddr == `CCPM_OFS_STATE);

    always_comb begin
        rd_val = 32'h0;
        case (i_apb.paddr)
            `CCPM_OFS_CTRL: begin
                rd_val[`CCPM_CTRL_CURLIM_MSB:0] = cur_lim_r;
                rd_val[`CCPM_CTRL_TDIS_BIT] = tdis_r;
            end
            `CCPM_OFS_STATUS: rd_val[2:0] = status;
            `CCPM_OFS_MASK: rd_val[2:0] = mask_r;
            `CCPM_OFS_STATE: begin
                rd_val[3:0] = st_r;
                rd_val[`CCPM_STATE_CC_BIT] = o_const_current;
                rd_val[`CCPM_STATE_ARMED_BIT] = armed_r;
                rd_val[`CCPM_STATE_ATT_BIT] = attached_r;
                rd_val[`CCPM_STATE_HS_BIT] = o_hs_switch_closed;
            end
            default: rd_val = 32'h0;
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata <= 32'h0;
        end else begin
            o_pready <= setup;
            o_pslverr <= setup & ~mapped;
            o_prdata <= (setup && !i_apb.pwrite) ? rd_val : 32'h0;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cur_lim_r <= `CCPM_RST_CURLIM;
            tdis_r <= `CCPM_RST_TDIS;
        end else if (wr && i_apb.paddr == `CCPM_OFS_CTRL) begin
            cur_lim_r <= i_apb.pwdata[`CCPM_CTRL_CURLIM_MSB:0];
            tdis_r <= i_apb.pwdata[`CCPM_CTRL_TDIS_BIT];
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mask_r <= `CCPM_RST_MASK;
        end else if (wr && i_apb.paddr == `CCPM_OFS_MASK) begin
            mask_r <= i_apb.pwdata[2:0];
        end
    end

    assign clr = (wr && i_apb.paddr == `CCPM_OFS_STATUS) ? i_apb.pwdata[2:0] : 3'h0;

    ccpm_irq_bank #(
        .N(`CCPM_NUM_EV)
    ) u_irq (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_set({miss_evt, rem_evt, att_evt}),
        .i_clr(clr),
        .i_mask(mask_r),
        .o_status(status),
        .o_irq(o_irq)
    );

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);

    sequence s_force;
        i_detect_feature_enable && (mode_chg || pwr_rise);
    endsequence

    sequence s_rearmed;
        status[`CCPM_EV_REMOVAL] && armed_r && !attached_r;
    endsequence

    sequence s_unpowered_hold;
        (!i_port_power_enable && !mode_chg)[*3];
    endsequence

    sequence s_quiet_fall;
        i_detect_feature_enable && attached_r && !i_load_present && !mode_chg && !pwr_rise;
    endsequence

    a_pass_hold: assert property (
        (st_r == CCPM_ST_PASS && !mode_chg) |=> st_r == CCPM_ST_PASS)
        else $error("pass-through left without mode change");

    a_pass_unpowered: assert property (
        (st_r == CCPM_ST_PASS ##0 s_unpowered_hold) |=> (st_r == CCPM_ST_PASS && o_hs_switch_closed))
        else $error("pass-through dropped on power disable");

    a_pass_persist: assert property (
        (st_r == CCPM_ST_PASS && !i_port_power_enable && !mode_chg
         && (i_mode == 3'h2 || i_mode == 3'h6)) |=> st_r == CCPM_ST_PASS ##0 o_hs_switch_closed)
        else $error("pass-through not persisting unpowered");

    a_cdp_cc_limit: assert property (
        (st_r == CCPM_ST_CDP && cur_lim_r < `CCPM_CURLIM_CC_MAX_MA) |=> o_const_current)
        else $error("constant current not selected");

    a_trip_limit: assert property (
        (st_r != CCPM_ST_CDP || cur_lim_r >= `CCPM_CURLIM_CC_MAX_MA) |=> !o_const_current)
        else $error("trip behaviour not selected");

    a_forced_removal: assert property (
        s_force |=> s_rearmed)
        else $error("forced removal missing");

    a_cdp_no_dp_miss: assert property (
        (s_quiet_fall ##0 (st_r == CCPM_ST_CDP && !dp_seen_r))
        |-> (!rem_evt ##1 (status[`CCPM_EV_MISSED] && !o_attached)))
        else $error("removal raised for load without DP");

    a_miss_rearm: assert property (
        (miss_evt ##1 (i_load_present && i_detect_feature_enable && !mode_chg && !pwr_rise))
        |=> (o_attached && status[`CCPM_EV_ATTACH]))
        else $error("attach not resumed after missed removal");

    a_custom_no_removal: assert property (
        (s_quiet_fall ##0 (tdis_r && i_profile_cycling_pass)) |-> (!rem_evt ##1 !attached_r))
        else $error("removal detected with timeout disabled");

    a_detect_off: assert property (
        !i_detect_feature_enable |-> (!att_evt && !rem_evt ##1 !o_attached))
        else $error("detection active while disabled");

    a_sleep_switch: assert property (
        st_r == CCPM_ST_SLEEP |-> !o_hs_switch_closed)
        else $error("high-speed switch closed in sleep");

endmodule

// *** rtl/ccpm_consts.svh ***
`ifndef CCPM_CONSTS_SVH
`define CCPM_CONSTS_SVH

// Register byte offsets
`define CCPM_OFS_CTRL 8'h00
`define CCPM_OFS_STATUS 8'h04
`define CCPM_OFS_MASK 8'h08
`define CCPM_OFS_STATE 8'h0c

// Control register fields
`define CCPM_CTRL_CURLIM_MSB 11
`define CCPM_CTRL_TDIS_BIT 16

// Status and mask bit positions
`define CCPM_EV_ATTACH 0
`define CCPM_EV_REMOVAL 1
`define CCPM_EV_MISSED 2
`define CCPM_NUM_EV 3

// State register fields
`define CCPM_STATE_CC_BIT 4
`define CCPM_STATE_ARMED_BIT 5
`define CCPM_STATE_ATT_BIT 6
`define CCPM_STATE_HS_BIT 7

// Reset values
`define CCPM_RST_CURLIM 12'h1f4
`define CCPM_RST_TDIS 1'h0
`define CCPM_RST_MASK 3'h0

// Current limit threshold in mA, 1.5 A
`define CCPM_CURLIM_CC_MAX_MA 12'h5dc

`endif

// *** rtl/ccpm_pkg.sv ***
// Purpose: Types shared by the charge port mode and detect control
// Assumes: One-hot state codes
// Notes: Offsets and fields live in ccpm_consts.svh
package ccpm_pkg;

    typedef enum logic [3:0] {
        CCPM_ST_SLEEP = 4'h1,
        CCPM_ST_PASS = 4'h2,
        CCPM_ST_CDP = 4'h4,
        CCPM_ST_DCP = 4'h8
    } ccpm_state_t;

    typedef struct packed {
        logic mode_select_one;
        logic mode_select_two;
        logic emulation_enable;
    } ccpm_mode_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } ccpm_apb_req_t;

endpackage

// *** rtl/ccpm_irq_bank.sv ***
// Purpose: Sticky event bits with write-one-to-clear and masked interrupt
// Assumes: Set and clear are one-cycle pulses per bit
// Notes: Set wins over a clear in the same cycle
module ccpm_irq_bank #(
    parameter int N = 3
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic [N-1:0] i_set,
    input wire logic [N-1:0] i_clr,
    input wire logic [N-1:0] i_mask,
    output logic [N-1:0] o_status,
    output logic o_irq
);

    logic [N-1:0] status_nxt;

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_bit
            assign status_nxt[g] = i_set[g] | (o_status[g] & ~i_clr[g]);
            always_ff @(posedge i_core_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    o_status[g] <= 1'b0;
                end else begin
                    o_status[g] <= status_nxt[g];
                end
            end
        end
    endgenerate

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(status_nxt & i_mask);
        end
    end

endmodule

// *** sim/ccpm_load_model.sv ***
// Purpose: Portable device attached to the charging port
// Assumes: Plug and DP follow bench commands one edge later
// Notes: A power thief attaches without ever driving DP
module ccpm_load_model (
    input wire logic i_core_clk,
    input wire logic i_plug,
    input wire logic i_std,
    output logic o_load_present,
    output logic o_dp_driven
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        o_load_present = 1'b0;
        o_dp_driven = 1'b0;
    end

    always @(posedge i_core_clk) begin
        o_load_present <= i_plug;
        // Only a standard device drives DP
        o_dp_driven <= i_plug & i_std;
    end
endmodule

// *** sim/tb_top.sv ***
// Purpose: Self-checking bench for the charge port mode and detect control
// Assumes: Zero-wait APB slave, registered outputs
// Notes: Load model plays the attached portable device
`include "ccpm_consts.svh"

module tb_top
    import ccpm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [7:0] CTL = `CCPM_OFS_CTRL;
    localparam logic [7:0] STS = `CCPM_OFS_STATUS;
    localparam logic [7:0] MSK = `CCPM_OFS_MASK;
    localparam logic [7:0] STT = `CCPM_OFS_STATE;

    logic clk;
    logic rst_n;
    ccpm_apb_req_t apb;
    ccpm_mode_t mode;
    logic [31:0] prdata;
    logic [31:0] q;
    logic pready, pslverr, e, pwr, det, plug, std, pcp, load, dp, hs, cc, att, irq;
    int bad_count;
    int n_tests;
    logic [2:0] tm [5] = '{3'b010, 3'b110, 3'b111, 3'b011, 3'b000};
    logic [3:0] ts [5] = '{4'h2, 4'h2, 4'h4, 4'h8, 4'h1};

    ccpm_top ccpm_top_i (.i_core_clk(clk), .i_rst_n(rst_n), .i_apb(apb), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_mode(mode), .i_port_power_enable(pwr),
        .i_detect_feature_enable(det), .i_load_present(load), .i_dp_driven(dp),
        .i_profile_cycling_pass(pcp), .o_hs_switch_closed(hs), .o_const_current(cc),
        .o_attached(att), .o_irq(irq));

    ccpm_load_model ccpm_load_model_i (.i_core_clk(clk), .i_plug(plug), .i_std(std),
        .o_load_present(load), .o_dp_driven(dp));

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // One APB transfer; holds the request until pready is sampled high, for at most 8 cycles
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        apb <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk);
        apb.penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 8);
        chk("pready", 1, pready);
        q = prdata;
        e = pslverr;
        apb <= '0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
        repeat (2) @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x, input string nm);
        xfer(1'b0, a, 32'h0);
        chk(nm, x, q & m);
    endtask

    task automatic pins(input logic [2:0] m, input logic p);
        @(posedge clk);
        mode <= ccpm_mode_t'(m);
        pwr <= p;
        repeat (3) @(posedge clk);
    endtask

    task automatic pl(input logic p, input logic s);
        @(posedge clk);
        plug <= p;
        std <= s;
        repeat (4) @(posedge clk);
    endtask

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial begin
        #200us;
        bad_count++;
        conclude();
    end

    initial begin
        rst_n = 1'b0;
        apb = '0;
        mode = '0;
        {pwr, det, plug, std, pcp} = 5'h08;
        bad_count = 0;
        n_tests = 0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        rd(CTL, 32'h1ffff, 32'h1f4, "ctrl");
        rd(MSK, 32'h7, 32'h0, "mask");
        rd(STT, 32'hf, 32'h1, "state");
        xfer(1'b0, 8'h10, 32'h0);
        chk("slverr", 1, e);
        chk("rdata", 0, q);
        $display("test reset done");
        for (int i = 0; i < 5; i++) begin
            pins(tm[i], 1'b1);
            rd(STT, 32'hf, {28'h0, ts[i]}, "state");
            chk("hs", {31'h0, ts[i] == 4'h2 || ts[i] == 4'h4}, hs);
        end
        pins(3'b010, 1'b1);
        pins(3'b010, 1'b0);
        rd(STT, 32'hf, 32'h2, "state");
        chk("hs", 1, hs);
        pins(3'b110, 1'b1);
        pins(3'b110, 1'b0);
        rd(STT, 32'hf, 32'h2, "state");
        pins(3'b110, 1'b1);
        pins(3'b111, 1'b1);
        rd(STT, 32'hf, 32'h4, "state");
        pins(3'b010, 1'b1);
        pins(3'b000, 1'b1);
        pins(3'b000, 1'b0);
        chk("hs", 0, hs);
        $display("test modes done");
        pins(3'b111, 1'b1);
        wr(CTL, 32'h5db);
        chk("cc", 1, cc);
        wr(CTL, 32'h5dc);
        chk("cc", 0, cc);
        $display("test limit done");
        wr(MSK, 32'h7);
        wr(STS, 32'h7);
        chk("irq", 0, irq);
        pins(3'b011, 1'b1);
        rd(STS, 32'h2, 32'h2, "status");
        chk("irq", 1, irq);
        wr(STS, 32'h2);
        chk("irq", 0, irq);
        pins(3'b011, 1'b0);
        wr(STS, 32'h7);
        pins(3'b011, 1'b1);
        rd(STS, 32'h2, 32'h2, "status");
        wr(MSK, 32'h0);
        chk("irq", 0, irq);
        wr(STS, 32'h7);
        $display("test events done");
        pl(1'b1, 1'b1);
        chk("att", 1, att);
        rd(STS, 32'h7, 32'h1, "status");
        pl(1'b0, 1'b0);
        chk("att", 0, att);
        rd(STS, 32'h7, 32'h3, "status");
        pins(3'b111, 1'b1);
        wr(STS, 32'h7);
        pl(1'b1, 1'b0);
        // Thief pulled, standard device plugged one cycle later
        @(posedge clk);
        plug <= 1'b0;
        @(posedge clk);
        {plug, std} <= 2'b11;
        repeat (4) @(posedge clk);
        rd(STS, 32'h7, 32'h5, "status");
        chk("att", 1, att);
        wr(STS, 32'h7);
        pl(1'b0, 1'b0);
        rd(STS, 32'h7, 32'h2, "status");
        $display("test detect done");
        wr(CTL, 32'h105dc);
        wr(STS, 32'h7);
        @(posedge clk);
        pcp <= 1'b1;
        pl(1'b1, 1'b1);
        pl(1'b0, 1'b0);
        rd(STS, 32'h7, 32'h5, "status");
        wr(CTL, 32'h5dc);
        wr(STS, 32'h7);
        pl(1'b1, 1'b1);
        pl(1'b0, 1'b0);
        rd(STS, 32'h7, 32'h3, "status");
        @(posedge clk);
        {pcp, det} <= 2'b00;
        wr(STS, 32'h7);
        pl(1'b1, 1'b1);
        chk("att", 0, att);
        pl(1'b0, 1'b0);
        pins(3'b011, 1'b1);
        rd(STS, 32'h7, 32'h0, "status");
        $display("test profile and disable done");
        conclude();
    end
endmodule
